// [verilog/bst_timing.sv]
`timescale 1ns/10ps
`include "bst_defines.svh"
module bst_timing #(
  parameter int OD_CYC_25 = 25 * `BST_CYC_PER_MS,
  parameter int OD_CYC_50 = 50 * `BST_CYC_PER_MS,
  parameter int OD_CYC_100 = 100 * `BST_CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  input wire logic is_erm,
  input wire logic cal_or_diag,
  input wire logic meas_start,
  input wire logic od_active,
  output logic meas_busy,
  output logic adc_sample,
  output logic od_clamp,
  output logic [15:0] sample_offset_cyc,
  output logic [15:0] zc_window_cyc,
  output logic code_unavail
);
  bst_pkg::bst_reg28_t r28_q;
  bst_pkg::bst_reg29_t r29_q;
  bst_pkg::bst_state_t st_q, st_d;
  logic [13:0] wait_q, wait_d;
  logic [22:0] od_cnt_q;
  logic od_clamp_q, adc_q;
  logic [15:0] smp_q, zcw_q;

  // Wait table in microseconds, LRA and ERM
  function automatic logic [13:0] wait_cyc(input logic [3:0] code, input logic erm);
    logic [8:0] us;
    us = 9'h0;
    if (erm) begin
      unique case (code[1:0])
        2'h0: us = 9'd45;
        2'h1: us = 9'd75;
        2'h2: us = 9'd150;
        default: us = 9'd225;
      endcase
    end else begin
      unique case (code)
        4'h0: us = 9'd15;
        4'h1: us = 9'd25;
        4'h2: us = 9'd50;
        4'h3: us = 9'd75;
        4'h4: us = 9'd90;
        4'h5: us = 9'd105;
        4'h6: us = 9'd120;
        4'h7: us = 9'd135;
        4'h8: us = 9'd150;
        4'h9: us = 9'd165;
        4'ha: us = 9'd180;
        4'hb: us = 9'd195;
        4'hc: us = 9'd210;
        4'hd: us = 9'd235;
        4'he: us = 9'd260;
        default: us = 9'd285;
      endcase
    end
    wait_cyc = 14'(us * `BST_CYC_PER_US);
  endfunction

  wire sel28 = (reg_addr == `BST_REG_SETTLE_DISCH);
  wire sel29 = (reg_addr == `BST_REG_OD_SAMPLE_ZC);
  wire [7:0] r28_raw = r28_q;
  wire [7:0] r29_raw = r29_q;
  assign reg_rdata = sel28 ? r28_raw : (sel29 ? r29_raw : 8'h00);

  wire [3:0] settle_code = r28_q.settle;
  wire [3:0] disch_code = r28_q.disch;
  // ERM codes above 3 are unavailable; flagged and folded onto the code given by their low two bits
  assign code_unavail = is_erm && ((settle_code > 4'h3) || (disch_code > 4'h3));
  wire [13:0] settle_cyc = wait_cyc(settle_code, is_erm);
  wire [13:0] disch_cyc = wait_cyc(disch_code, is_erm);

  // Limit ignored during calibration or diagnostics
  wire od_lim_en = (r29_q.od_limit != 2'h0) && !cal_or_diag;
  wire [22:0] od_lim_cyc = (r29_q.od_limit == 2'h1) ? 23'(OD_CYC_25) :
                           (r29_q.od_limit == 2'h2) ? 23'(OD_CYC_50) : 23'(OD_CYC_100);

  always_comb begin
    st_d = st_q;
    wait_d = wait_q;
    unique case (st_q)
      bst_pkg::BST_IDLE: if (meas_start) begin
        st_d = bst_pkg::BST_DISCH;
        wait_d = disch_cyc - 14'h1;
      end
      bst_pkg::BST_DISCH: if (wait_q == 14'h0) begin
        st_d = bst_pkg::BST_SETTLE;
        wait_d = settle_cyc - 14'h1;
      end else begin
        wait_d = wait_q - 14'h1;
      end
      bst_pkg::BST_SETTLE: if (wait_q == 14'h0) begin
        st_d = bst_pkg::BST_SAMPLE;
      end else begin
        wait_d = wait_q - 14'h1;
      end
      bst_pkg::BST_SAMPLE: st_d = bst_pkg::BST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r28_q <= `BST_RST_SETTLE_DISCH;
      r29_q <= `BST_RST_OD_SAMPLE_ZC;
    end else if (reg_wr && sel28) begin
      r28_q <= reg_wdata;
    end else if (reg_wr && sel29) begin
      r29_q <= reg_wdata & `BST_REG29_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= bst_pkg::BST_IDLE;
      wait_q <= 14'h0;
      adc_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      adc_q <= (st_d == bst_pkg::BST_SAMPLE);
    end
  end

  // Counter restarts each overdrive or braking period
  always_ff @(posedge clk) begin
    if (!rst_b || !od_active) begin
      od_cnt_q <= 23'h0;
      od_clamp_q <= 1'b0;
    end else begin
      if (od_cnt_q != od_lim_cyc) od_cnt_q <= od_cnt_q + 23'h1;
      od_clamp_q <= od_lim_en && (od_cnt_q + 23'h1 >= od_lim_cyc);
    end
  end

  wire [15:0] smp_sel = (r29_q.sample == 2'h0) ? 16'(`BST_SMP_0_US * `BST_CYC_PER_US) :
                        (r29_q.sample == 2'h1) ? 16'(`BST_SMP_1_US * `BST_CYC_PER_US) :
                        (r29_q.sample == 2'h2) ? 16'(`BST_SMP_2_US * `BST_CYC_PER_US) :
                        16'(`BST_SMP_3_US * `BST_CYC_PER_US);
  wire [15:0] zcw_sel = (r29_q.zc_win == 2'h0) ? 16'(`BST_ZC_0_US * `BST_CYC_PER_US) :
                        (r29_q.zc_win == 2'h1) ? 16'(`BST_ZC_1_US * `BST_CYC_PER_US) :
                        (r29_q.zc_win == 2'h2) ? 16'(`BST_ZC_2_US * `BST_CYC_PER_US) :
                        16'(`BST_ZC_3_US * `BST_CYC_PER_US);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      smp_q <= 16'h0;
      zcw_q <= 16'h0;
    end else begin
      smp_q <= smp_sel;
      zcw_q <= zcw_sel;
    end
  end

  assign meas_busy = (st_q != bst_pkg::BST_IDLE);
  assign adc_sample = adc_q;
  assign od_clamp = od_clamp_q && od_active && !cal_or_diag;
  assign sample_offset_cyc = smp_q;
  assign zc_window_cyc = zcw_q;
endmodule

// [verilog/bst_defines.svh]
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH
`define BST_REG_SETTLE_DISCH 8'h28
`define BST_REG_OD_SAMPLE_ZC 8'h29
`define BST_RST_SETTLE_DISCH 8'h11
`define BST_RST_OD_SAMPLE_ZC 8'h0c
`define BST_SETTLE_MSB 7
`define BST_SETTLE_LSB 4
`define BST_DISCH_MSB 3
`define BST_DISCH_LSB 0
`define BST_ODLIM_MSB 5
`define BST_ODLIM_LSB 4
`define BST_SAMPLE_MSB 3
`define BST_SAMPLE_LSB 2
`define BST_ZCW_MSB 1
`define BST_ZCW_LSB 0
`define BST_REG29_MASK 8'h3f
`define BST_CLK_MHZ 40
`define BST_CYC_PER_US `BST_CLK_MHZ
`define BST_CYC_PER_MS (`BST_CLK_MHZ * 1000)
`define BST_OD_25_MS 25
`define BST_OD_50_MS 50
`define BST_OD_100_MS 100
`define BST_ZC_0_US 100
`define BST_ZC_1_US 200
`define BST_ZC_2_US 300
`define BST_ZC_3_US 390
`define BST_SMP_0_US 150
`define BST_SMP_1_US 200
`define BST_SMP_2_US 250
`define BST_SMP_3_US 300
`endif

// [verilog/bst_pkg.sv]
package bst_pkg;
  typedef enum logic [1:0] {
    BST_IDLE = 2'b00,
    BST_DISCH = 2'b01,
    BST_SETTLE = 2'b10,
    BST_SAMPLE = 2'b11
  } bst_state_t;

  typedef struct packed {
    logic [3:0] settle;
    logic [3:0] disch;
  } bst_reg28_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [1:0] od_limit;
    logic [1:0] sample;
    logic [1:0] zc_win;
  } bst_reg29_t;
endpackage

// [testbench/bst_timing_chk.sv]
`timescale 1ns/10ps
module bst_timing_chk #(
  parameter int OD_CYC_25 = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic is_erm,
  input wire logic cal_or_diag,
  input wire logic meas_start,
  input wire logic od_active,
  input wire logic meas_busy,
  input wire logic adc_sample,
  input wire logic od_clamp,
  input wire logic [15:0] sample_offset_cyc,
  input wire logic [15:0] zc_window_cyc,
  input wire logic code_unavail
);
  int odc_q;
  always_ff @(posedge clk) odc_q <= (!rst_b || !od_active) ? 0 : odc_q + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_start; meas_start && !meas_busy |=> meas_busy; endproperty
  a_start: assert property (p_start) else $error("no busy after start");
  property p_adc_end; adc_sample |-> meas_busy ##1 !meas_busy; endproperty
  a_adc_end: assert property (p_adc_end) else $error("busy wrong around sample");
  property p_adc_gap; $rose(meas_busy) |-> !adc_sample [*8]; endproperty
  a_adc_gap: assert property (p_adc_gap) else $error("sample too early");
  property p_cal; cal_or_diag |-> !od_clamp; endproperty
  a_cal: assert property (p_cal) else $error("clamp during calibration");
  property p_clamp_act; od_clamp |-> od_active; endproperty
  a_clamp_act: assert property (p_clamp_act) else $error("clamp outside overdrive");
  property p_clamp_min; od_clamp |-> odc_q >= OD_CYC_25; endproperty
  a_clamp_min: assert property (p_clamp_min) else $error("clamp too early");
  property p_unavail; code_unavail |-> is_erm; endproperty
  a_unavail: assert property (p_unavail) else $error("unavailable flag on LRA");
  property p_wr29;
    reg_wr && reg_addr == 8'h29 ##1 reg_addr == 8'h29 |-> reg_rdata == ($past(reg_wdata) & 8'h3f);
  endproperty
  a_wr29: assert property (p_wr29) else $error("offset register write lost");
  c_adc: cover property (adc_sample);
  c_clamp: cover property (od_clamp);
  c_unav: cover property (code_unavail);
endmodule
bind bst_timing bst_timing_chk #(.OD_CYC_25(OD_CYC_25)) u_chk (.*);

// [testbench/bst_act_model.sv]
`timescale 1ns/10ps
module bst_act_model (
  input wire logic kick,
  input wire logic erm_type,
  output logic od_active,
  output logic is_erm
);
  // Overdrive phase lasts as long as the kick is requested
  assign od_active = kick;
  assign is_erm = erm_type;
endmodule

// [testbench/tb_bst_timing.sv]
`timescale 1ns/10ps
module tb_bst_timing;
  logic clk = 0, rst_b = 0, reg_wr = 0, cal_or_diag = 0, meas_start = 0, kick = 0, erm = 0;
  logic is_erm, od_active, meas_busy, adc_sample, od_clamp, code_unavail;
  logic [7:0] reg_addr = 8'h28, reg_wdata = 8'h00, reg_rdata;
  logic [15:0] sample_offset_cyc, zc_window_cyc;
  int mismatches = 0, num_checks = 0, cyc = 0, n;
  logic [23:0] rows [5] = '{24'h28ffff, 24'h29ff3f, 24'h2a5500, 24'h284040, 24'h291010};
  always #12.5 clk = ~clk;
  bst_timing #(.OD_CYC_25(20), .OD_CYC_50(40), .OD_CYC_100(80)) u_dut (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .is_erm(is_erm), .cal_or_diag(cal_or_diag), .meas_start(meas_start), .od_active(od_active),
    .meas_busy(meas_busy), .adc_sample(adc_sample), .od_clamp(od_clamp),
    .sample_offset_cyc(sample_offset_cyc), .zc_window_cyc(zc_window_cyc),
    .code_unavail(code_unavail));
  bst_act_model u_act (.kick(kick), .erm_type(erm), .od_active(od_active), .is_erm(is_erm));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1;
    #1 chk(reg_rdata, 8'h11);
    reg_addr = 8'h29;
    #1 chk(reg_rdata, 8'h0c);
    @(negedge clk);
    meas_start = 1;
    @(negedge clk);
    n = 0;
    // A second start mid-wait must not restart the count
    while (adc_sample !== 1'b1 && n < 5000) begin
      meas_start = (n == 10);
      @(negedge clk);
      n++;
    end
    chk(n, 2000);
    @(negedge clk);
    chk(meas_busy, 0);
    chk(sample_offset_cyc, 16'h2ee0);
    chk(zc_window_cyc, 16'h0fa0);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      #1 chk(reg_rdata, rows[i][7:0]);
    end
    chk(code_unavail, 0);
    erm = 1;
    #1 chk(code_unavail, 1);
    wr(8'h28, 8'h33);
    #1 chk(code_unavail, 0);
    for (int c = 1; c < 4; c++) begin
      wr(8'h29, 8'(c << 4));
      kick = 1;
      n = 0;
      while (od_clamp !== 1'b1 && n < 200) begin
        @(negedge clk);
        n++;
      end
      chk(n, 16'(10 << c));
      chk(sample_offset_cyc, 16'h1770);
      chk(zc_window_cyc, 16'h0fa0);
      cal_or_diag = 1;
      #1 chk(od_clamp, 0);
      cal_or_diag = 0;
      kick = 0;
    end
    wr(8'h29, 8'h0c);
    kick = 1;
    repeat (100) @(negedge clk);
    chk(od_clamp, 0);
    kick = 0;
    report_and_stop();
  end
endmodule
